// *** fpc_pkg.sv ***
// shared constants, register map and types of the flash program/erase controller
package fpc_pkg;
  // clock rate used to turn times into cycle counts
  localparam int CLK_MHZ = 125;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] ADR_CTRL     = 8'h00; // flash_op_control
  localparam logic [7:0] ADR_KEY      = 8'h04; // flash_unlock_key, write only
  localparam logic [7:0] ADR_TPAGE    = 8'h08; // table_page_register
  localparam logic [7:0] ADR_TOFFSET  = 8'h0C; // in-page table offset
  localparam logic [7:0] ADR_LATCH_LO = 8'h10; // table write, low word
  localparam logic [7:0] ADR_LATCH_HI = 8'h14; // table write, high byte, offset += 2

  // control register field positions
  localparam int CTRL_WR_BIT    = 15; // start, set only
  localparam int CTRL_PROGRAM_ERASE_ENABLE_BIT  = 14; // program_erase_enable
  localparam int CTRL_ERR_BIT   = 13; // sequence_error_flag
  localparam int CTRL_ERASE_BIT = 6;  // erase select
  localparam int CTRL_OP_LSB    = 0;  // flash_op_select low bit
  localparam int CTRL_OP_MSB    = 3;  // flash_op_select high bit
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // unlock key values, in this order
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;

  // flash_op_select codes
  localparam logic [3:0] OP_ROW  = 4'h1; // row program (erase = 0)
  localparam logic [3:0] OP_PAGE = 4'h2; // page erase (erase = 1)
  localparam logic [3:0] OP_WORD = 4'h3; // word program (erase = 0)
  localparam logic [3:0] OP_BULK = 4'hF; // bulk erase (erase = 1)

  // array geometry in program-counter units (two per instruction)
  localparam int ROW_WORDS = 64;  // 64 instructions, 192 bytes
  localparam int ROW_LSB   = 7;   // row base alignment
  localparam int BLOCK_LSB = 10;  // 8-row block, 512 instructions, 1536 bytes
  localparam logic [5:0] ROW_LAST = 6'h3F;

  // operation times in microseconds (arbitrary plain defaults)
  localparam int WORD_TIME_US  = 40;
  localparam int ROW_TIME_US   = 2000;
  localparam int PAGE_TIME_US  = 20000;
  localparam int BULK_TIME_US  = 40000;

  // sequencer states
  typedef enum logic [1:0] {FPC_IDLE, FPC_ROW, FPC_WAIT} fpc_state_t;

  // unlock key tracker
  typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_ARMED} fpc_key_t;

  // request to the flash array, one-cycle strobes
  typedef struct packed {
    logic        wr;    // program one instruction word
    logic        erase; // erase block or whole array
    logic        bulk;  // erase whole array
    logic [23:0] addr;  // program memory address
    logic [23:0] data;  // instruction word to program
  } fpc_flash_req_t;
endpackage

// *** fpc_ctrl.sv ***
// flash program/erase sequencer with wishbone register slave
`timescale 1ns/1ps
module fpc_ctrl
  import fpc_pkg::*;
#(
  parameter int WORD_TIME = WORD_TIME_US, // word program time, us
  parameter int ROW_TIME  = ROW_TIME_US,  // row program time, us
  parameter int PAGE_TIME = PAGE_TIME_US, // page erase time, us
  parameter int BULK_TIME = BULK_TIME_US  // bulk erase time, us
) (
  input  wire logic           CLK_IN,        // system clock
  input  wire logic           RESETN_IN,     // power-on reset, async
  input  wire logic           SYS_RESET_IN,  // any other reset, sync
  input  wire logic           SERIAL_MODE_IN,// external serial programming mode
  input  wire logic           WB_CYC_IN,     // wishbone cycle
  input  wire logic           WB_STB_IN,     // wishbone strobe
  input  wire logic           WB_WE_IN,      // wishbone write
  input  wire logic [7:0]     WB_ADR_IN,     // wishbone byte address
  input  wire logic [3:0]     WB_SEL_IN,     // wishbone byte enables
  input  wire logic [31:0]    WB_DAT_IN,     // wishbone write data
  output logic      [31:0]    WB_DAT_OUT,    // wishbone read data
  output logic                WB_ACK_OUT,    // wishbone acknowledge
  output logic                CPU_STALL_OUT, // processor stall
  output fpc_flash_req_t      FLASH_REQ_OUT  // flash array request
);

  // cycle counts derived from the times
  localparam logic [31:0] WORD_CYC = 32'(WORD_TIME * CLK_MHZ);
  localparam logic [31:0] ROW_CYC  = 32'(ROW_TIME * CLK_MHZ);
  localparam logic [31:0] PAGE_CYC = 32'(PAGE_TIME * CLK_MHZ);
  localparam logic [31:0] BULK_CYC = 32'(BULK_TIME * CLK_MHZ);

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] wmerge16(input logic [15:0] old_v,
                                           input logic [15:0] new_v,
                                           input logic [1:0]  sel);
    wmerge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
                sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // word address match
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  // state registers
  fpc_state_t     st_r, st_nxt;       // sequencer state
  fpc_key_t       key_r, key_nxt;     // unlock tracker
  logic           busy_r, busy_nxt;   // operation in progress, reads as start bit
  logic           program_erase_enable_r;             // program_erase_enable
  logic           err_r, err_nxt;     // sequence_error_flag
  logic           erase_r;            // erase select
  logic [3:0]     op_r;               // flash_op_select
  logic [7:0]     tpage_r;            // table page
  logic [15:0]    toff_r;             // table offset
  logic [5:0]     idx_r, idx_nxt;     // row word index
  logic [31:0]    cnt_r, cnt_nxt;     // self-timing counter
  logic           ack_r;              // bus acknowledge
  logic [31:0]    dat_r;              // bus read data
  fpc_flash_req_t req_r, req_nxt;     // flash strobe register
  logic [23:0]    latch [ROW_WORDS];  // write latches

  // bus decode
  wire        req_w    = WB_CYC_IN & WB_STB_IN & ~ack_r;
  wire        wreq_w   = req_w & WB_WE_IN;
  wire        hit_ctrl = hit(WB_ADR_IN, ADR_CTRL);
  wire        hit_key  = hit(WB_ADR_IN, ADR_KEY);
  wire        hit_pg   = hit(WB_ADR_IN, ADR_TPAGE);
  wire        hit_off  = hit(WB_ADR_IN, ADR_TOFFSET);
  wire        hit_lo   = hit(WB_ADR_IN, ADR_LATCH_LO);
  wire        hit_hi   = hit(WB_ADR_IN, ADR_LATCH_HI);
  wire [5:0]  lat_idx  = toff_r[ROW_LSB-1:1];

  // control register as read: unimplemented bits tie to zero
  wire [15:0] ctrl_rd  = {busy_r, program_erase_enable_r, err_r, 6'h00, erase_r, 2'h0, op_r};
  wire [15:0] ctrl_wd  = wmerge16(ctrl_rd, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
  wire        ctrl_wr  = wreq_w & hit_ctrl & ~busy_r;

  // operation decode from the value being written
  wire        n_erase  = ctrl_wd[CTRL_ERASE_BIT];
  wire [3:0]  n_op     = ctrl_wd[CTRL_OP_MSB:CTRL_OP_LSB];
  wire        is_word  = ~n_erase & (n_op == OP_WORD);
  wire        is_row   = ~n_erase & (n_op == OP_ROW);
  wire        is_page  = n_erase & (n_op == OP_PAGE);
  wire        is_bulk  = n_erase & (n_op == OP_BULK) & SERIAL_MODE_IN;
  // anything else, including mis-paired codes, counts as unimplemented
  wire        op_ok    = is_word | is_row | is_page | is_bulk;

  // start attempt: the start bit can only be set, never cleared here
  wire        try_go   = ctrl_wr & ctrl_wd[CTRL_WR_BIT];
  wire        go       = try_go & (key_r == KEY_ARMED) & ctrl_wd[CTRL_PROGRAM_ERASE_ENABLE_BIT] & op_ok;
  wire        bad      = try_go & ~go;
  wire        abort    = SYS_RESET_IN & busy_r; // termination of a running operation

  // load value of the self-timer
  wire [31:0] cnt_load = is_word ? WORD_CYC : (is_page ? PAGE_CYC : BULK_CYC);

  // addresses: rows and blocks are edge-aligned from address zero
  wire [23:0] row_addr = {tpage_r, toff_r[15:ROW_LSB], idx_r, 1'b0};
  wire [23:0] blk_addr = {tpage_r, toff_r[15:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
  wire [23:0] wrd_addr = {tpage_r, toff_r[15:1], 1'b0};

  // read data selection; key and unmapped addresses read zero
  wire [31:0] rd_data  = hit_ctrl ? {16'h0000, ctrl_rd} :
                         hit_pg   ? {24'h000000, tpage_r} :
                         hit_off  ? {16'h0000, toff_r} :
                         hit_lo   ? {16'h0000, latch[lat_idx][15:0]} :
                         hit_hi   ? {24'h000000, latch[lat_idx][23:16]} : 32'h00000000;

  // unlock tracker: two key writes in a row, any other write breaks it
  always_comb begin
    key_nxt = key_r;
    if (SYS_RESET_IN) begin
      key_nxt = KEY_IDLE;
    end else if (wreq_w) begin
      if (hit_key && WB_SEL_IN[0] && WB_DAT_IN[7:0] == KEY_FIRST) begin
        key_nxt = KEY_HALF;
      end else if (hit_key && WB_SEL_IN[0] && key_r == KEY_HALF &&
                   WB_DAT_IN[7:0] == KEY_SECOND) begin
        key_nxt = KEY_ARMED;
      end else begin
        key_nxt = KEY_IDLE; // arming is used up by the next write of any kind
      end
    end
  end

  // error flag: hardware set beats a software clear in the same cycle
  always_comb begin
    err_nxt = err_r;
    if (bad || abort) begin
      err_nxt = 1'b1;
    end else if (go) begin
      err_nxt = 1'b0;
    end else if (ctrl_wr) begin
      err_nxt = ctrl_wd[CTRL_ERR_BIT];
    end
  end

  // sequencer: launch, strobe the array, then run out the self-timer
  always_comb begin
    st_nxt   = st_r;
    idx_nxt  = idx_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    req_nxt  = '0;
    case (st_r)
      FPC_IDLE: begin
        if (go) begin
          busy_nxt = 1'b1;
          cnt_nxt  = cnt_load;
          if (is_row) begin
            idx_nxt = 6'h00;
            st_nxt  = FPC_ROW;
          end else if (is_word) begin
            req_nxt.wr   = 1'b1;
            req_nxt.addr = wrd_addr;
            req_nxt.data = latch[lat_idx];
            st_nxt       = FPC_WAIT;
          end else begin
            req_nxt.erase = 1'b1;
            req_nxt.bulk  = is_bulk;
            req_nxt.addr  = is_bulk ? 24'h000000 : blk_addr;
            st_nxt        = FPC_WAIT;
          end
        end
      end
      FPC_ROW: begin
        // one latch word per cycle, all 64 of the row
        req_nxt.wr   = 1'b1;
        req_nxt.addr = row_addr;
        req_nxt.data = latch[idx_r];
        idx_nxt      = idx_r + 6'h01;
        if (idx_r == ROW_LAST) begin
          cnt_nxt = ROW_CYC;
          st_nxt  = FPC_WAIT;
        end
      end
      FPC_WAIT: begin
        if (cnt_r <= 32'h00000001) begin
          busy_nxt = 1'b0;
          st_nxt   = FPC_IDLE;
        end else begin
          cnt_nxt = cnt_r - 32'h00000001;
        end
      end
      default: begin
        st_nxt   = FPC_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
    // other resets end the operation; the enable, erase and op bits keep their values
    if (SYS_RESET_IN) begin
      st_nxt   = FPC_IDLE;
      busy_nxt = 1'b0;
      req_nxt  = '0;
    end
  end

  // sequencer and strobe flops
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_r   <= FPC_IDLE;
      busy_r <= 1'b0;
      idx_r  <= 6'h00;
      cnt_r  <= 32'h00000000;
      req_r  <= '0;
    end else begin
      st_r   <= st_nxt;
      busy_r <= busy_nxt;
      idx_r  <= idx_nxt;
      cnt_r  <= cnt_nxt;
      req_r  <= req_nxt;
    end
  end

  // control fields: only the power-on reset returns them to zero
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      program_erase_enable_r  <= CTRL_RESET[CTRL_PROGRAM_ERASE_ENABLE_BIT];
      erase_r <= CTRL_RESET[CTRL_ERASE_BIT];
      op_r    <= CTRL_RESET[CTRL_OP_MSB:CTRL_OP_LSB];
      err_r   <= CTRL_RESET[CTRL_ERR_BIT];
      key_r   <= KEY_IDLE;
    end else begin
      err_r <= err_nxt;
      key_r <= key_nxt;
      if (ctrl_wr) begin
        program_erase_enable_r  <= ctrl_wd[CTRL_PROGRAM_ERASE_ENABLE_BIT];
        erase_r <= n_erase;
        op_r    <= n_op;
      end
    end
  end

  // table pointer: page, offset, and post-increment after the high byte
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tpage_r <= 8'h00;
      toff_r  <= 16'h0000;
    end else if (wreq_w && !busy_r) begin
      if (hit_pg && WB_SEL_IN[0]) begin
        tpage_r <= WB_DAT_IN[7:0];
      end else if (hit_off) begin
        toff_r <= wmerge16(toff_r, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
      end else if (hit_hi) begin
        toff_r <= toff_r + 16'h0002;
      end
    end
  end

  // write latches hold table writes until a program runs; not reset, like the array
  always_ff @(posedge CLK_IN) begin
    if (wreq_w && !busy_r && hit_lo) begin
      latch[lat_idx][15:0] <= wmerge16(latch[lat_idx][15:0], WB_DAT_IN[15:0],
                                       WB_SEL_IN[1:0]);
    end else if (wreq_w && !busy_r && hit_hi && WB_SEL_IN[0]) begin
      latch[lat_idx][23:16] <= WB_DAT_IN[7:0];
    end
  end

  // bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req_w;
      if (req_w && !WB_WE_IN) begin
        dat_r <= rd_data;
      end
    end
  end

  // outputs straight from flops
  assign WB_ACK_OUT    = ack_r;
  assign WB_DAT_OUT    = dat_r;
  assign CPU_STALL_OUT = busy_r;
  assign FLASH_REQ_OUT = req_r;

endmodule

// *** fpc_ctrl_sva.sv ***
// port-level assertion checker for the flash program/erase controller
`timescale 1ns/1ps
module fpc_ctrl_sva
  import fpc_pkg::*;
(
  input wire logic           CLK_IN,
  input wire logic           RESETN_IN,
  input wire logic           SYS_RESET_IN,
  input wire logic           SERIAL_MODE_IN,
  input wire logic           WB_CYC_IN,
  input wire logic           WB_STB_IN,
  input wire logic           WB_WE_IN,
  input wire logic [7:0]     WB_ADR_IN,
  input wire logic [3:0]     WB_SEL_IN,
  input wire logic [31:0]    WB_DAT_IN,
  input wire logic [31:0]    WB_DAT_OUT,
  input wire logic           WB_ACK_OUT,
  input wire logic           CPU_STALL_OUT,
  input wire fpc_flash_req_t FLASH_REQ_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // request taken this edge at the control register
  wire taken   = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && WB_ADR_IN[7:2] == ADR_CTRL[7:2];
  wire ctrl_rd = taken && !WB_WE_IN;
  wire launch  = taken && WB_WE_IN && WB_DAT_IN[15] && WB_DAT_IN[14];
  a_strobe_busy: assert property ((FLASH_REQ_OUT.wr || FLASH_REQ_OUT.erase) |-> CPU_STALL_OUT)
    else $error("flash strobe outside a busy period");
  a_idle_quiet: assert property (!CPU_STALL_OUT |-> FLASH_REQ_OUT == '0)
    else $error("flash request while idle");
  a_start_cause: assert property ($rose(CPU_STALL_OUT) |-> $past(launch))
    else $error("operation began without an enabled start write");
  a_erase_pick: assert property ($rose(CPU_STALL_OUT) && $past(WB_DAT_IN[6]) |-> FLASH_REQ_OUT.erase)
    else $error("erase select did not give an erase");
  a_prog_pick: assert property ($rose(CPU_STALL_OUT) && !$past(WB_DAT_IN[6]) |->
    !FLASH_REQ_OUT.erase ##[0:1] FLASH_REQ_OUT.wr)
    else $error("program select did not give a program strobe");
  a_bulk_serial: assert property (FLASH_REQ_OUT.bulk |-> FLASH_REQ_OUT.erase && $past(SERIAL_MODE_IN))
    else $error("bulk erase outside serial mode");
  a_block_align: assert property (FLASH_REQ_OUT.erase && !FLASH_REQ_OUT.bulk |->
    FLASH_REQ_OUT.addr[9:0] == 10'h000)
    else $error("erase block not aligned");
  a_unimpl_zero: assert property (WB_ACK_OUT && $past(ctrl_rd) |->
    WB_DAT_OUT[12:7] == 6'h00 && WB_DAT_OUT[5:4] == 2'h0)
    else $error("unimplemented control bits read nonzero");
  a_busy_reads: assert property (WB_ACK_OUT && $past(ctrl_rd) |-> WB_DAT_OUT[15] == $past(CPU_STALL_OUT))
    else $error("start bit does not follow busy");
endmodule
bind fpc_ctrl fpc_ctrl_sva fpc_ctrl_sva_inst (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
  .SYS_RESET_IN(SYS_RESET_IN), .SERIAL_MODE_IN(SERIAL_MODE_IN), .WB_CYC_IN(WB_CYC_IN),
  .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN),
  .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
  .CPU_STALL_OUT(CPU_STALL_OUT), .FLASH_REQ_OUT(FLASH_REQ_OUT));

// *** fpc_cpu_model.sv ***
// wishbone master standing in for the core software
`timescale 1ns/1ps
module fpc_cpu_model
  import fpc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  output logic             cyc_out,
  output logic             stb_out,
  output logic             we_out,
  output logic [7:0]       adr_out,
  output logic [3:0]       sel_out,
  output logic [31:0]      dat_out
);
  // idle bus at time zero
  initial begin
    {cyc_out, stb_out, we_out, adr_out, sel_out, dat_out} = '0;
  end
  // one classic cycle, held until ack is sampled, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] s, output logic [31:0] q);
    @(posedge clk_in);
    {cyc_out, stb_out, we_out, adr_out, sel_out} <= {2'b11, w, a, s};
    dat_out <= {~d, d}; // upper lanes carry junk the block must ignore
    do @(posedge clk_in); while (ack_in !== 1'b1);
    q = dat_in;
    {cyc_out, stb_out, we_out} <= 3'b000;
    dat_out <= ~dat_out; // stale data never looks valid
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, 4'hF, q);
  endtask
  // write with a chosen set of byte lanes
  task automatic wr_sel(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] q;
    xfer(1'b1, a, d, s, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 16'h0000, 4'hF, q);
  endtask
  // unlock pair then start; caller has set the op code first
  task automatic launch(input logic [15:0] ctl);
    wr(ADR_KEY, {8'h00, KEY_FIRST});
    wr(ADR_KEY, {8'h00, KEY_SECOND});
    wr(ADR_CTRL, ctl | 16'h8000);
    repeat (2) @(posedge clk_in);
  endtask
  // poll the start bit; a hang is cut by the bench timeout
  task automatic wait_done();
    logic [31:0] q;
    q = 32'h00008000;
    while (q[15] !== 1'b0) rd(ADR_CTRL, q);
  endtask
endmodule

// *** fpc_ctrl_tb_top.sv ***
// self-checking testbench for the flash program/erase controller
`timescale 1ns/1ps
module fpc_ctrl_tb_top;
  import fpc_pkg::*;
  logic           clk_in = 1'b0;      // 125 MHz system clock
  logic           resetn_in = 1'b0;   // power-on reset, low
  logic           sys_reset_in = 1'b0;
  logic           serial_mode_in = 1'b0;
  logic           wb_cyc, wb_stb, wb_we, wb_ack, stall;
  logic [7:0]     wb_adr;
  logic [3:0]     wb_sel;
  logic [31:0]    wb_dat_w, wb_dat_r;
  fpc_flash_req_t req;
  int             err_total = 0;
  int             checks_done = 0;
  int             cyc_cnt = 0;
  int             wr_cnt = 0, er_cnt = 0, stall_len = 0, row_bad = 0;
  logic [23:0]    last_addr, last_data;
  logic           bulk_seen;

  always #4 clk_in = ~clk_in;

  // short op times: word, page and bulk operations last 125 cycles, a row program 189 (64 strobes then 125)
  fpc_ctrl #(.WORD_TIME(1), .ROW_TIME(1), .PAGE_TIME(1), .BULK_TIME(1)) fpc_ctrl_inst (
    .CLK_IN(clk_in), .RESETN_IN(resetn_in), .SYS_RESET_IN(sys_reset_in),
    .SERIAL_MODE_IN(serial_mode_in), .WB_CYC_IN(wb_cyc), .WB_STB_IN(wb_stb),
    .WB_WE_IN(wb_we), .WB_ADR_IN(wb_adr), .WB_SEL_IN(wb_sel), .WB_DAT_IN(wb_dat_w),
    .WB_DAT_OUT(wb_dat_r), .WB_ACK_OUT(wb_ack), .CPU_STALL_OUT(stall), .FLASH_REQ_OUT(req));
  fpc_cpu_model fpc_cpu_model_inst (.clk_in(clk_in), .ack_in(wb_ack), .dat_in(wb_dat_r),
    .cyc_out(wb_cyc), .stb_out(wb_stb), .we_out(wb_we), .adr_out(wb_adr),
    .sel_out(wb_sel), .dat_out(wb_dat_w));

  // flash side monitor and hang limit
  always @(posedge clk_in) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
    if (stall === 1'b1) stall_len <= stall_len + 1;
    if (req.wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      last_addr <= req.addr;
      last_data <= req.data;
      if (req.data[5:0] !== req.addr[6:1]) row_bad <= row_bad + 1; // latch data tracks index
    end
    if (req.erase === 1'b1) begin
      er_cnt <= er_cnt + 1;
      last_addr <= req.addr;
      bulk_seen <= req.bulk;
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    logic [31:0] q;
    fpc_cpu_model_inst.rd(a, q);
    chk(nm, {16'h0000, exp}, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    fpc_cpu_model_inst.wr(a, d);
  endtask
  task automatic clr();
    {wr_cnt, er_cnt, stall_len, row_bad} = '0;
  endtask

  task automatic t_reset();
    rchk("ctrl reset", ADR_CTRL, CTRL_RESET);
    wr(ADR_CTRL, 16'h1FB0);
    rchk("ctrl unimpl", ADR_CTRL, 16'h0000);
    rchk("key read", ADR_KEY, 16'h0000);
    rchk("unmapped", 8'h3C, 16'h0000);
    fpc_cpu_model_inst.wr_sel(ADR_TOFFSET, 16'h1234, 4'h1);
    rchk("lane low", ADR_TOFFSET, 16'h0034);
    fpc_cpu_model_inst.wr_sel(ADR_TOFFSET, 16'hAB00, 4'h2);
    rchk("lane high", ADR_TOFFSET, 16'hAB34);
    $display("test reset done");
  endtask
  task automatic t_word();
    wr(ADR_TPAGE, 16'h0012);
    wr(ADR_TOFFSET, 16'h0046);
    wr(ADR_LATCH_LO, 16'hBEE3);
    wr(ADR_LATCH_HI, 16'h00A5);
    wr(ADR_TOFFSET, 16'h0046);
    wr(ADR_CTRL, 16'h4003);
    clr();
    fpc_cpu_model_inst.launch(16'h4003);
    rchk("busy", ADR_CTRL, 16'hC003);
    fpc_cpu_model_inst.wait_done();
    chk("word stall", 125, stall_len);
    chk("word strobes", 1, wr_cnt);
    chk("word addr", 24'h120046, last_addr);
    chk("word data", 24'hA5BEE3, last_data);
    rchk("word end", ADR_CTRL, 16'h4003);
    $display("test word done");
  endtask
  task automatic t_row();
    wr(ADR_TPAGE, 16'h0003);
    wr(ADR_TOFFSET, 16'h0180);
    for (logic [6:0] i = 7'h00; i < 7'h40; i++) begin
      wr(ADR_LATCH_LO, {10'h040, i[5:0]});
      wr(ADR_LATCH_HI, 16'h005A);
    end
    wr(ADR_TOFFSET, 16'h0180);
    wr(ADR_CTRL, 16'h4001);
    clr();
    fpc_cpu_model_inst.launch(16'h4001);
    fpc_cpu_model_inst.wait_done();
    chk("row strobes", 64, wr_cnt);
    chk("row order", 0, row_bad);
    chk("row last addr", 24'h0301FE, last_addr);
    chk("row last data", 24'h5A103F, last_data);
    rchk("row end", ADR_CTRL, 16'h4001);
    $display("test row done");
  endtask
  task automatic t_page();
    wr(ADR_CTRL, 16'h4042);
    wr(ADR_TPAGE, 16'h0005);
    wr(ADR_TOFFSET, 16'h07C6);
    wr(ADR_LATCH_LO, 16'h0000);
    clr();
    fpc_cpu_model_inst.launch(16'h4042);
    fpc_cpu_model_inst.wait_done();
    chk("page erases", 1, er_cnt);
    chk("page addr", 24'h050400, last_addr);
    chk("page bulk", 0, bulk_seen);
    chk("page stall", 125, stall_len);
    $display("test page done");
  endtask
  task automatic t_bulk();
    wr(ADR_CTRL, 16'h404F);
    clr();
    fpc_cpu_model_inst.launch(16'h404F);
    rchk("bulk refused", ADR_CTRL, 16'h604F);
    chk("bulk none", 0, er_cnt);
    @(posedge clk_in);
    serial_mode_in <= 1'b1;
    fpc_cpu_model_inst.launch(16'h404F);
    fpc_cpu_model_inst.wait_done();
    chk("bulk erases", 1, er_cnt);
    chk("bulk flag", 1, bulk_seen);
    chk("bulk addr", 0, last_addr);
    rchk("bulk end", ADR_CTRL, 16'h404F);
    serial_mode_in <= 1'b0;
    $display("test bulk done");
  endtask
  task automatic t_refuse();
    logic [15:0] ctl [6] = '{16'hC003, 16'h8003, 16'hC043, 16'hC002, 16'hC004, 16'hC003};
    int km [6] = '{0, 1, 1, 1, 1, 2};
    for (int i = 0; i < 6; i++) begin
      clr();
      wr(ADR_CTRL, 16'h0000); // error flag starts clear, so each pass must set it
      if (km[i] != 0) wr(ADR_KEY, 16'h0055);
      if (km[i] == 2) wr(ADR_TPAGE, 16'h0000);
      if (km[i] != 0) wr(ADR_KEY, 16'h00AA);
      wr(ADR_CTRL, ctl[i]);
      rchk("refused ctrl", ADR_CTRL, (ctl[i] & 16'h7FFF) | 16'h2000);
      chk("refused strobes", 0, wr_cnt + er_cnt);
    end
    $display("test refuse done");
  endtask
  task automatic t_abort();
    fpc_cpu_model_inst.launch(16'h4003);
    repeat (10) @(posedge clk_in);
    sys_reset_in <= 1'b1;
    @(posedge clk_in);
    sys_reset_in <= 1'b0;
    rchk("abort ctrl", ADR_CTRL, 16'h6003);
    chk("abort stall", 0, stall);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    resetn_in <= 1'b1;
    rchk("por ctrl", ADR_CTRL, CTRL_RESET);
    $display("test abort done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_reset();
    t_word();
    t_row();
    t_page();
    t_bulk();
    t_refuse();
    t_abort();
    report_and_stop();
  end
endmodule
